// ==== bim_params.svh ====
// Constants of the interrupt enable and mask block: register indices,
// field positions, writable-bit masks and reset values.
// Assumes inclusion by bare name from the package and the modules.
`ifndef BIM_PARAMS_SVH
`define BIM_PARAMS_SVH

// ****************************************
// Register indices, byte address = 4 * index
// ****************************************
`define BIM_IDX_OUT_EN      8'he0
`define BIM_IDX_MASK_A      8'he1
`define BIM_IDX_MASK_B      8'he2
`define BIM_IDX_STAT_A      8'he5
`define BIM_IDX_STAT_B      8'he6

// ****************************************
// Field positions
// ****************************************
`define BIM_BIT_GLOBAL_EN   0
`define BIM_BIT_SYNC        7
`define BIM_BIT_CHECKSUM    6
`define BIM_BIT_UNCORR      5
`define BIM_BIT_CORR        4
`define BIM_BIT_PROTOCOL    3
`define BIM_BIT_LEADER      2
`define BIM_BIT_UNLOCK      0

// ****************************************
// Live (non-reserved) bits of each register
// ****************************************
`define BIM_LIVE_OUT_EN     8'h01
`define BIM_LIVE_CHAN_A     8'hfd
`define BIM_LIVE_CHAN_B     8'hfc

// ****************************************
// Reset values
// ****************************************
`define BIM_RST_OUT_EN      8'h00
`define BIM_RST_MASK        8'h00
`define BIM_RST_STAT_A      8'h01
`define BIM_RST_STAT_B      8'h00

// ****************************************
// Bus geometry
// ****************************************
`define BIM_IDX_LSB         2
`define BIM_IDX_MSB         9

`endif

// ==== bim_pkg.sv ====
// Types and the register decode shared by the block's modules.
// Assumes bim_params.svh is on the include path.
`include "bim_params.svh"

package bim_pkg;

    typedef logic [7:0] bim_byte_t;

    typedef enum {
        BIM_R_NONE,
        BIM_R_OUT_EN,
        BIM_R_MASK_A,
        BIM_R_MASK_B,
        BIM_R_STAT_A,
        BIM_R_STAT_B
    } bim_reg_t;

    typedef enum {
        BIM_BUS_IDLE,
        BIM_BUS_ACK
    } bim_bus_state_t;

    function automatic bim_reg_t bim_decode(input bim_byte_t idx, input logic inRange);
        bim_reg_t r;
        r = BIM_R_NONE;
        if (!inRange) begin
            r = BIM_R_NONE;
        end else if (idx == `BIM_IDX_OUT_EN) begin
            r = BIM_R_OUT_EN;
        end else if (idx == `BIM_IDX_MASK_A) begin
            r = BIM_R_MASK_A;
        end else if (idx == `BIM_IDX_MASK_B) begin
            r = BIM_R_MASK_B;
        end else if (idx == `BIM_IDX_STAT_A) begin
            r = BIM_R_STAT_A;
        end else if (idx == `BIM_IDX_STAT_B) begin
            r = BIM_R_STAT_B;
        end
        return r;
    endfunction

endpackage

// ==== bim_flag_if.sv ====
// Carrier between the core and one sticky flag bank.
// Assumes the core drives set and clear pulses in the sys_clk domain.
interface bim_flag_if #(
    parameter int W = 8
);
    logic [W-1:0] setEvt;
    logic [W-1:0] clrMask;
    logic [W-1:0] flags;

    modport core (
        output setEvt,
        output clrMask,
        input  flags
    );

    modport bank (
        input  setEvt,
        input  clrMask,
        output flags
    );
endinterface

// ==== bim_flag_bank.sv ====
// Sticky status flags, set by hardware events, cleared by write-one.
// Assumes set and clear arrive as one-cycle pulses on sys_clk.
module bim_flag_bank #(
    parameter logic [7:0] RST_VAL  = 8'h00,
    parameter logic [7:0] LIVE_MSK = 8'hff
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Flag carrier
    bim_flag_if.bank fl
);

    logic [7:0] flags_r;
    logic [7:0] flags_nxt;

    // Set after clear, so an event in the clearing cycle survives
    always_comb begin
        flags_nxt = ((flags_r & ~fl.clrMask) | fl.setEvt) & LIVE_MSK;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags_r <= RST_VAL;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign fl.flags = flags_r;

endmodule

// ==== bim_core.sv ====
// Interrupt enable and mask core with its Wishbone slave.
// Assumes classic Wishbone on sys_clk and error events as one-cycle pulses.
//
// The Wishbone register port is this design's own decision.
`include "bim_params.svh"

module bim_core #(
    parameter int ADR_W = 10
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Error events, one-cycle pulses: sync, checksum, uncorr, corr, protocol, leader
    input  wire logic [5:0]        aErrEvt,
    input  wire logic [5:0]        bErrEvt,
    // Lock status level
    input  wire logic              pllLocked,
    // Interrupt pin
    output logic                   irqOut,
    output logic                   irqOe
);

    // ****************************************
    // Bus slave
    // ****************************************
    bim_pkg::bim_bus_state_t busState_r;
    bim_pkg::bim_bus_state_t busState_nxt;
    logic [31:0]             rdData_r;
    logic [31:0]             rdData_nxt;
    logic                    ack_r;
    logic                    ack_nxt;
    logic                    inRange;
    bim_pkg::bim_reg_t       regSel;
    bim_pkg::bim_byte_t      rdByte;
    logic                    wrCommit;
    bim_pkg::bim_byte_t      wrByte;

    assign inRange = ((wb_adr_i >> (`BIM_IDX_MSB + 1)) == '0);
    assign regSel  = bim_pkg::bim_decode(wb_adr_i[`BIM_IDX_MSB:`BIM_IDX_LSB], inRange);
    assign wrByte  = wb_dat_i[7:0];

    // A write lands only at the edge where ack is seen, and only for lane 0
    assign wrCommit = (busState_r == bim_pkg::BIM_BUS_ACK) && wb_cyc_i && wb_stb_i
                      && wb_we_i && wb_sel_i[0];

    always_comb begin
        busState_nxt = busState_r;
        rdData_nxt   = rdData_r;
        ack_nxt      = 1'h0;
        case (busState_r)
            bim_pkg::BIM_BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    busState_nxt = bim_pkg::BIM_BUS_ACK;
                    ack_nxt      = 1'b1;
                    rdData_nxt   = {24'h000000, rdByte};
                end
            end
            bim_pkg::BIM_BUS_ACK: begin
                busState_nxt = bim_pkg::BIM_BUS_IDLE;
            end
            default: begin
                busState_nxt = bim_pkg::BIM_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busState_r <= bim_pkg::BIM_BUS_IDLE;
            rdData_r   <= 32'h00000000;
            ack_r      <= 1'h0;
        end else begin
            busState_r <= busState_nxt;
            rdData_r   <= rdData_nxt;
            ack_r      <= ack_nxt;
        end
    end

    assign wb_dat_o = rdData_r;
    assign wb_ack_o = ack_r;

    // ****************************************
    // Enable and mask registers
    // ****************************************
    bim_pkg::bim_byte_t outEn_r;
    bim_pkg::bim_byte_t outEn_nxt;
    bim_pkg::bim_byte_t maskA_r;
    bim_pkg::bim_byte_t maskA_nxt;
    bim_pkg::bim_byte_t maskB_r;
    bim_pkg::bim_byte_t maskB_nxt;

    always_comb begin
        outEn_nxt = outEn_r;
        maskA_nxt = maskA_r;
        maskB_nxt = maskB_r;
        if (wrCommit && regSel == bim_pkg::BIM_R_OUT_EN) begin
            outEn_nxt = wrByte & `BIM_LIVE_OUT_EN;
        end
        if (wrCommit && regSel == bim_pkg::BIM_R_MASK_A) begin
            maskA_nxt = wrByte & `BIM_LIVE_CHAN_A;
        end
        if (wrCommit && regSel == bim_pkg::BIM_R_MASK_B) begin
            maskB_nxt = wrByte & `BIM_LIVE_CHAN_B;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            outEn_r <= `BIM_RST_OUT_EN;
            maskA_r <= `BIM_RST_MASK;
            maskB_r <= `BIM_RST_MASK;
        end else begin
            outEn_r <= outEn_nxt;
            maskA_r <= maskA_nxt;
            maskB_r <= maskB_nxt;
        end
    end

    // Named mask fields
    logic a_sync_error_mask_bit;
    logic a_checksum_error_mask_bit;
    logic a_uncorrectable_mask_bit;
    logic a_correctable_mask_bit;
    logic a_protocol_error_mask_bit;
    logic a_leader_bit_mask_bit;
    logic unlockMaskBit;
    logic b_sync_error_mask_bit;
    logic b_checksum_error_mask_bit;
    logic b_uncorrectable_mask_bit;
    logic b_correctable_mask_bit;
    logic b_protocol_error_mask_bit;
    logic b_leader_bit_mask_bit;

    assign a_sync_error_mask_bit     = maskA_r[`BIM_BIT_SYNC];
    assign a_checksum_error_mask_bit = maskA_r[`BIM_BIT_CHECKSUM];
    assign a_uncorrectable_mask_bit  = maskA_r[`BIM_BIT_UNCORR];
    assign a_correctable_mask_bit    = maskA_r[`BIM_BIT_CORR];
    assign a_protocol_error_mask_bit = maskA_r[`BIM_BIT_PROTOCOL];
    assign a_leader_bit_mask_bit     = maskA_r[`BIM_BIT_LEADER];
    assign unlockMaskBit             = maskA_r[`BIM_BIT_UNLOCK];
    assign b_sync_error_mask_bit     = maskB_r[`BIM_BIT_SYNC];
    assign b_checksum_error_mask_bit = maskB_r[`BIM_BIT_CHECKSUM];
    assign b_uncorrectable_mask_bit  = maskB_r[`BIM_BIT_UNCORR];
    assign b_correctable_mask_bit    = maskB_r[`BIM_BIT_CORR];
    assign b_protocol_error_mask_bit = maskB_r[`BIM_BIT_PROTOCOL];
    assign b_leader_bit_mask_bit     = maskB_r[`BIM_BIT_LEADER];

    // ****************************************
    // Lock-loss detection
    // ****************************************
    logic lockPrev_r;
    logic lockPrev_nxt;
    logic unlockEvt;

    // Reset to zero so a lock missing after reset is not a false loss
    always_comb begin
        lockPrev_nxt = pllLocked;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lockPrev_r <= 1'h0;
        end else begin
            lockPrev_r <= lockPrev_nxt;
        end
    end

    assign unlockEvt = lockPrev_r && !pllLocked;

    // ****************************************
    // Status flag banks
    // ****************************************
    bim_flag_if #(.W(8)) flA ();
    bim_flag_if #(.W(8)) flB ();

    assign flA.setEvt  = {aErrEvt, 1'h0, unlockEvt};
    assign flB.setEvt  = {bErrEvt, 2'h0};
    assign flA.clrMask = (wrCommit && regSel == bim_pkg::BIM_R_STAT_A) ? wrByte : 8'h00;
    assign flB.clrMask = (wrCommit && regSel == bim_pkg::BIM_R_STAT_B) ? wrByte : 8'h00;

    bim_flag_bank #(
        .RST_VAL  (`BIM_RST_STAT_A),
        .LIVE_MSK (`BIM_LIVE_CHAN_A)
    ) u_statA (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .fl      (flA.bank)
    );

    bim_flag_bank #(
        .RST_VAL  (`BIM_RST_STAT_B),
        .LIVE_MSK (`BIM_LIVE_CHAN_B)
    ) u_statB (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .fl      (flB.bank)
    );

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rdByte = 8'h00;
        if (regSel == bim_pkg::BIM_R_OUT_EN) begin
            rdByte = outEn_r;
        end else if (regSel == bim_pkg::BIM_R_MASK_A) begin
            rdByte = maskA_r;
        end else if (regSel == bim_pkg::BIM_R_MASK_B) begin
            rdByte = maskB_r;
        end else if (regSel == bim_pkg::BIM_R_STAT_A) begin
            rdByte = flA.flags;
        end else if (regSel == bim_pkg::BIM_R_STAT_B) begin
            rdByte = flB.flags;
        end
    end

    // ****************************************
    // Interrupt pin
    // ****************************************
    logic       irq_r;
    logic       irq_nxt;
    logic       pending;
    logic [7:0] maskAUsed;
    logic [7:0] maskBUsed;

    // Masks rebuilt from the named fields; reserved positions are forced to zero
    assign maskAUsed = {a_sync_error_mask_bit, a_checksum_error_mask_bit,
                        a_uncorrectable_mask_bit, a_correctable_mask_bit,
                        a_protocol_error_mask_bit, a_leader_bit_mask_bit,
                        1'h0, unlockMaskBit};
    assign maskBUsed = {b_sync_error_mask_bit, b_checksum_error_mask_bit,
                        b_uncorrectable_mask_bit, b_correctable_mask_bit,
                        b_protocol_error_mask_bit, b_leader_bit_mask_bit,
                        2'h0};

    assign pending = (|(flA.flags & maskAUsed)) || (|(flB.flags & maskBUsed));

    always_comb begin
        irq_nxt = outEn_r[`BIM_BIT_GLOBAL_EN] && pending;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_r <= 1'h0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // Enable straight from the register; level one cycle behind the flags
    assign irqOe  = outEn_r[`BIM_BIT_GLOBAL_EN];
    assign irqOut = irq_r;

endmodule

// ==== bim_core_props.sv ====
// Concurrent checks on the ports of the interrupt enable and mask core.
// Assumes it is bound to bim_core and sees only that module's ports.
module bim_core_props #(
    parameter int ADR_W = 10
) (
    // Clock and reset
    input wire logic             sys_clk,
    input wire logic             rst_n,
    // Wishbone slave side
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    // Events and lock
    input wire logic [5:0]       aErrEvt,
    input wire logic [5:0]       bErrEvt,
    input wire logic             pllLocked,
    // Interrupt pin
    input wire logic             irqOut,
    input wire logic             irqOe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence sReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence sEnWrite;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_W'(10'h380);
    endsequence
    sequence sRd(logic [7:0] idx);
        wb_ack_o && !wb_we_i && wb_adr_i == ADR_W'({idx, 2'h0});
    endsequence

    a_ack_follows: assert property (sReq |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_oe_follow: assert property (sEnWrite |=> irqOe == $past(wb_dat_i[0]))
        else $error("pin enable not updated");
    a_oe_quiet: assert property (!irqOe && !$past(irqOe) |-> !irqOut)
        else $error("pin driven while disabled");
    a_irq_needs_oe: assert property (irqOut |-> $past(irqOe))
        else $error("interrupt without enable");
    a_mask_a_resv: assert property (sRd(8'he1) |-> !wb_dat_o[1])
        else $error("reserved mask bit set");
    a_mask_b_resv: assert property (sRd(8'he2) |-> wb_dat_o[1:0] == 2'h0)
        else $error("reserved mask bits set");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data nonzero");
endmodule

bind bim_core bim_core_props #(.ADR_W(ADR_W)) u_bim_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .aErrEvt(aErrEvt), .bErrEvt(bErrEvt),
    .pllLocked(pllLocked), .irqOut(irqOut), .irqOe(irqOe)
);

// ==== bim_host_model.sv ====
// Host side of the interrupt pin: resolves the wire it sees.
// Assumes no pull on the line, so a released pin is reported as such.
module bim_host_model (
    // Pin drive from the device
    input  wire logic       irqOut,
    input  wire logic       irqOe,
    // Seen pin: 2'h2 released, otherwise the driven level
    output logic      [1:0] pinState
);
    tri pinWire;
    assign pinWire = irqOe ? irqOut : 1'hz;
    assign pinState = (pinWire === 1'hz) ? 2'h2 : {1'h0, pinWire};
endmodule

// ==== bim_core_bench.sv ====
// Self-checking bench for the interrupt enable and mask core.
// Assumes bim_core, its checker and the host model are compiled first.
module bim_core_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        cyc = 1'h0;
    logic        stb = 1'h0;
    logic        we = 1'h0;
    logic [9:0]  adr = 10'h0;
    logic [3:0]  sel = 4'h0;
    logic [3:0]  lane = 4'h1;
    logic [31:0] datW = 32'h0;
    logic [31:0] datR;
    logic        ack;
    logic [5:0]  aErr = 6'h0;
    logic [5:0]  bErr = 6'h0;
    logic        locked = 1'h1;
    logic        irqOut;
    logic        irqOe;
    logic [1:0]  pinState;
    logic [7:0]  rd;
    logic [7:0]  idx;
    logic [5:0]  ev;
    int          nMismatch = 0;
    int          cmpCount = 0;
    int          cycles = 0;

    bim_core i_bim_core (
        .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
        .aErrEvt(aErr), .bErrEvt(bErr), .pllLocked(locked), .irqOut(irqOut), .irqOe(irqOe)
    );
    bim_host_model i_bim_host_model (.irqOut(irqOut), .irqOe(irqOe), .pinState(pinState));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            nMismatch++;
            wrapUp();
        end
    end

    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge sys_clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {i, 2'h0};
        sel <= lane;
        datW <= {24'h0, d};
        do @(posedge sys_clk); while (ack !== 1'h1);
        rd = datR[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task automatic rdChk(input string nm, input logic [7:0] i, input logic [7:0] exp);
        xfer(1'h0, i, 8'h00);
        check(nm, rd, exp);
    endtask

    task automatic pinChk(input string nm, input logic [1:0] exp);
        check(nm, {6'h0, pinState}, {6'h0, exp});
    endtask

    // Event pulse for one cycle, then time for flag and pin to settle
    task automatic pulse(input logic [5:0] a, input logic [5:0] b);
        @(posedge sys_clk);
        aErr <= a;
        bErr <= b;
        @(posedge sys_clk);
        aErr <= 6'h0;
        bErr <= 6'h0;
        repeat (2) @(posedge sys_clk);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'h1;
        rdChk("outEn", 8'he0, 8'h00);
        rdChk("maskA", 8'he1, 8'h00);
        rdChk("maskB", 8'he2, 8'h00);
        rdChk("statA", 8'he5, 8'h01);
        rdChk("statB", 8'he6, 8'h00);
        pinChk("pinRst", 2'h2);
        $display("test reset done");
        xfer(1'h1, 8'he1, 8'hff);
        xfer(1'h1, 8'he2, 8'hff);
        xfer(1'h1, 8'he3, 8'hff);
        rdChk("maskA", 8'he1, 8'hfd);
        rdChk("maskB", 8'he2, 8'hfc);
        rdChk("unmapped", 8'he3, 8'h00);
        pinChk("pinOff", 2'h2);
        xfer(1'h1, 8'he0, 8'hff);
        rdChk("outEn", 8'he0, 8'h01);
        pinChk("pinLock", 2'h1);
        xfer(1'h1, 8'he5, 8'h00);
        rdChk("statA", 8'he5, 8'h01);
        xfer(1'h1, 8'he5, 8'h01);
        repeat (2) @(posedge sys_clk);
        pinChk("pinIdle", 2'h0);
        rdChk("statA", 8'he5, 8'h00);
        @(posedge sys_clk);
        locked <= 1'h0;
        repeat (3) @(posedge sys_clk);
        pinChk("pinUnlock", 2'h1);
        xfer(1'h1, 8'he1, 8'hfc);
        repeat (2) @(posedge sys_clk);
        pinChk("pinMaskLock", 2'h0);
        xfer(1'h1, 8'he5, 8'h01);
        locked <= 1'h1;
        $display("test lock done");
        xfer(1'h1, 8'he1, 8'h00);
        xfer(1'h1, 8'he2, 8'h00);
        lane = 4'h0;
        xfer(1'h1, 8'he2, 8'hff);
        lane = 4'h1;
        rdChk("laneOff", 8'he2, 8'h00);
        for (int i = 0; i < 12; i++) begin
            ev = 6'h1 << (i % 6);
            idx = (i < 6) ? 8'he1 : 8'he2;
            xfer(1'h1, idx, {ev, 2'h0});
            pulse((i < 6) ? ev : 6'h0, (i < 6) ? 6'h0 : ev);
            pinChk("pinEvt", 2'h1);
            xfer(1'h1, idx, 8'h00);
            rdChk("statSet", idx + 8'h04, {ev, 2'h0});
            pinChk("pinMasked", 2'h0);
            xfer(1'h1, idx + 8'h04, {ev, 2'h0});
            rdChk("statClr", idx + 8'h04, 8'h00);
        end
        // Event lands on the clearing edge: the set must win
        fork
            xfer(1'h1, 8'he6, 8'h80);
            begin
                repeat (2) @(posedge sys_clk);
                bErr <= 6'h20;
                @(posedge sys_clk);
                bErr <= 6'h00;
            end
        join
        rdChk("statSetWin", 8'he6, 8'h80);
        xfer(1'h1, 8'he6, 8'h80);
        rdChk("statClrB", 8'he6, 8'h00);
        xfer(1'h1, 8'he1, 8'h80);
        pulse(6'h20, 6'h0);
        xfer(1'h1, 8'he0, 8'h00);
        repeat (2) @(posedge sys_clk);
        pinChk("pinDisable", 2'h2);
        $display("test events done");
        wrapUp();
    end
endmodule
